// ### rtl/wdtip_cfg.svh
`ifndef WDTIP_CFG_SVH
`define WDTIP_CFG_SVH

// I/O port addresses
`define WDTIP_ADDR_INDEX 16'h002e
`define WDTIP_ADDR_DATA 16'h002f

// Key bytes on the index port
`define WDTIP_KEY_ENTER 8'h87
`define WDTIP_KEY_EXIT 8'haa

// Register indexes
`define WDTIP_IDX_GROUP 8'h07
`define WDTIP_IDX_ACT 8'h30
`define WDTIP_IDX_UNIT 8'hf5
`define WDTIP_IDX_COUNT 8'hf6
`define WDTIP_IDX_CTRL 8'hf7

// Group selector value of the watchdog group
`define WDTIP_GROUP_WDT 8'h08

// Field positions
`define WDTIP_ACT_ON_BIT 0
`define WDTIP_UNIT_MIN_BIT 3
`define WDTIP_UNIT_FAST_BIT 4
`define WDTIP_CTRL_MS_BIT 7
`define WDTIP_CTRL_KB_BIT 6
`define WDTIP_CTRL_FORCE_BIT 5
`define WDTIP_CTRL_STAT_BIT 4

// Reset values
`define WDTIP_RST_BYTE 8'h00
`define WDTIP_RST_COUNT 8'h00
`define WDTIP_RST_BIT 1'b0

// Timing
`define WDTIP_CLK_NS 25
`define WDTIP_MS_NS 1000000
`define WDTIP_MS_CYC (`WDTIP_MS_NS / `WDTIP_CLK_NS)
`define WDTIP_SEC_MS 1000
`define WDTIP_MIN_MS 60000
`define WDTIP_FAST_DIV 1000

`endif

// ### rtl/wdtip_pkg.sv
package wdtip_pkg;

  typedef enum logic [1:0] {
    WDTIP_LOCKED = 2'b00,
    WDTIP_KEY1 = 2'b01,
    WDTIP_OPEN = 2'b10
  } wdtip_cfg_t;

  typedef struct packed {
    wdtip_cfg_t cfg;
    logic [7:0] index;
    logic [7:0] group;
    logic act;
    logic unit_min;
    logic unit_fast;
    logic [7:0] count;
    logic [7:0] remain;
    logic kb_en;
    logic ms_en;
    logic status;
    logic expire_q;
    logic kb_q;
    logic ms_q;
    logic [7:0] rdata;
  } wdtip_state_t;

endpackage : wdtip_pkg

// ### rtl/wdtip_sync.sv
`timescale 1ns/1ps
module wdtip_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } wdtip_sync_t;

  wdtip_sync_t st_reg;
  wdtip_sync_t st_next;

  // Level accepted once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.filt = st_reg.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.filt;
endmodule : wdtip_sync

// ### rtl/wdtip_tick.sv
`timescale 1ns/1ps
module wdtip_tick #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic pulse;
  } wdtip_tick_t;

  wdtip_tick_t st_reg;
  wdtip_tick_t st_next;

  // One pulse every limit enabled cycles
  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (clr) begin
      st_next.cnt = '0;
    end else if (en) begin
      if (st_reg.cnt >= limit - W'(1)) begin
        st_next.cnt = '0;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;
endmodule : wdtip_tick

// ### rtl/wdtip_top.sv
// Summary of operation
// - Byte ports: index low, data high
// - Two enter keys unlock configuration
// - Exit key locks configuration again
// - Activation bit enables, reset disabled
// - Unit bit: seconds default, minutes
// - Fast bit ticks thousand times faster
// - Zero count holds timer stopped
// - Nonzero count expiry raises timeout
// - Count write restarts from new value
// - Keyboard activity restart enable, default off
// - Force bit makes timeout, self-clears
// - Status bit reads one after timeout
// - Top bit enables mouse activity restart
`timescale 1ns/1ps
`include "wdtip_cfg.svh"
module wdtip_top #(
  parameter int MS_CYCLES = `WDTIP_MS_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  input wire logic KB_ACT,
  input wire logic MS_ACT,
  output logic WDT_TIMEOUT,
  output logic WDT_EXPIRE,
  output logic CFG_OPEN
);
  import wdtip_pkg::*;

  localparam wdtip_state_t RST_STATE = '{
    cfg: WDTIP_LOCKED,
    index: `WDTIP_RST_BYTE,
    group: `WDTIP_RST_BYTE,
    act: `WDTIP_RST_BIT,
    unit_min: `WDTIP_RST_BIT,
    unit_fast: `WDTIP_RST_BIT,
    count: `WDTIP_RST_COUNT,
    remain: `WDTIP_RST_COUNT,
    kb_en: `WDTIP_RST_BIT,
    ms_en: `WDTIP_RST_BIT,
    status: `WDTIP_RST_BIT,
    expire_q: `WDTIP_RST_BIT,
    kb_q: `WDTIP_RST_BIT,
    ms_q: `WDTIP_RST_BIT,
    rdata: `WDTIP_RST_BYTE
  };

  wdtip_state_t st_reg;
  wdtip_state_t st_next;

  logic idx_wr;
  logic idx_rd;
  logic dat_wr;
  logic dat_rd;
  logic is_open;
  logic wdt_sel;
  logic running;
  logic ms_pulse;
  logic unit_pulse;
  logic kb_lvl;
  logic ms_lvl;
  logic kb_rise;
  logic ms_rise;
  logic restart;
  logic expire;
  logic force_to;
  logic clr_stat;
  logic [7:0] load_val;
  logic [7:0] rd_mux;
  logic [15:0] unit_limit;

  // Port decode
  assign idx_wr = IO_WR && (IO_ADDR == `WDTIP_ADDR_INDEX);
  assign idx_rd = IO_RD && (IO_ADDR == `WDTIP_ADDR_INDEX);
  assign dat_wr = IO_WR && (IO_ADDR == `WDTIP_ADDR_DATA);
  assign dat_rd = IO_RD && (IO_ADDR == `WDTIP_ADDR_DATA);
  assign is_open = (st_reg.cfg == WDTIP_OPEN);
  assign wdt_sel = (st_reg.group == `WDTIP_GROUP_WDT);

  // Countdown advances only when enabled with a live count
  assign running = st_reg.act && (st_reg.count != 8'h00) && (st_reg.remain != 8'h00);

  assign kb_rise = kb_lvl && !st_reg.kb_q;
  assign ms_rise = ms_lvl && !st_reg.ms_q;

  // Unit length in milliseconds
  always_comb begin
    case ({st_reg.unit_fast, st_reg.unit_min})
      2'b00: unit_limit = 16'(`WDTIP_SEC_MS);
      2'b01: unit_limit = 16'(`WDTIP_MIN_MS);
      2'b10: unit_limit = 16'(`WDTIP_SEC_MS / `WDTIP_FAST_DIV);
      2'b11: unit_limit = 16'(`WDTIP_MIN_MS / `WDTIP_FAST_DIV);
      default: unit_limit = 16'(`WDTIP_SEC_MS);
    endcase
  end

  wdtip_tick #(
    .W(16)
  ) u_ms_tick (
    .clk(CLK),
    .srst(SRST),
    .clr(restart),
    .en(1'b1),
    .limit(16'(MS_CYCLES)),
    .pulse(ms_pulse)
  );

  wdtip_tick #(
    .W(16)
  ) u_unit_tick (
    .clk(CLK),
    .srst(SRST),
    .clr(restart || !running),
    .en(ms_pulse && running),
    .limit(unit_limit),
    .pulse(unit_pulse)
  );

  wdtip_sync u_kb_sync (
    .clk(CLK),
    .srst(SRST),
    .din(KB_ACT),
    .dout(kb_lvl)
  );

  wdtip_sync u_ms_sync (
    .clk(CLK),
    .srst(SRST),
    .din(MS_ACT),
    .dout(ms_lvl)
  );

  // Data port read view
  always_comb begin
    rd_mux = 8'h00;
    if (st_reg.index == `WDTIP_IDX_GROUP) begin
      rd_mux = st_reg.group;
    end else if (wdt_sel) begin
      case (st_reg.index)
        `WDTIP_IDX_ACT: rd_mux[`WDTIP_ACT_ON_BIT] = st_reg.act;
        `WDTIP_IDX_UNIT: begin
          rd_mux[`WDTIP_UNIT_MIN_BIT] = st_reg.unit_min;
          rd_mux[`WDTIP_UNIT_FAST_BIT] = st_reg.unit_fast;
        end
        `WDTIP_IDX_COUNT: rd_mux = st_reg.count;
        `WDTIP_IDX_CTRL: begin
          rd_mux[`WDTIP_CTRL_MS_BIT] = st_reg.ms_en;
          rd_mux[`WDTIP_CTRL_KB_BIT] = st_reg.kb_en;
          rd_mux[`WDTIP_CTRL_STAT_BIT] = st_reg.status;
        end
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_comb begin
    st_next = st_reg;
    restart = 1'b0;
    expire = 1'b0;
    force_to = 1'b0;
    clr_stat = 1'b0;
    load_val = st_reg.count;
    st_next.kb_q = kb_lvl;
    st_next.ms_q = ms_lvl;

    // Configuration lock sequencer
    case (st_reg.cfg)
      WDTIP_LOCKED: begin
        if (idx_wr && IO_WDATA == `WDTIP_KEY_ENTER) begin
          st_next.cfg = WDTIP_KEY1;
        end
      end
      WDTIP_KEY1: begin
        if (idx_wr) begin
          st_next.cfg = (IO_WDATA == `WDTIP_KEY_ENTER) ? WDTIP_OPEN : WDTIP_LOCKED;
        end
      end
      WDTIP_OPEN: begin
        if (idx_wr) begin
          if (IO_WDATA == `WDTIP_KEY_EXIT) begin
            st_next.cfg = WDTIP_LOCKED;
          end else begin
            st_next.index = IO_WDATA;
          end
        end
      end
      default: st_next.cfg = WDTIP_LOCKED;
    endcase

    // Activity restarts
    if ((kb_rise && st_reg.kb_en) || (ms_rise && st_reg.ms_en)) begin
      restart = 1'b1;
    end

    // Register writes, only while unlocked
    if (dat_wr && is_open) begin
      if (st_reg.index == `WDTIP_IDX_GROUP) begin
        st_next.group = IO_WDATA;
      end else if (wdt_sel) begin
        case (st_reg.index)
          `WDTIP_IDX_ACT: st_next.act = IO_WDATA[`WDTIP_ACT_ON_BIT];
          `WDTIP_IDX_UNIT: begin
            st_next.unit_min = IO_WDATA[`WDTIP_UNIT_MIN_BIT];
            st_next.unit_fast = IO_WDATA[`WDTIP_UNIT_FAST_BIT];
          end
          `WDTIP_IDX_COUNT: begin
            st_next.count = IO_WDATA;
            load_val = IO_WDATA;
            restart = 1'b1;
          end
          `WDTIP_IDX_CTRL: begin
            st_next.ms_en = IO_WDATA[`WDTIP_CTRL_MS_BIT];
            st_next.kb_en = IO_WDATA[`WDTIP_CTRL_KB_BIT];
            force_to = IO_WDATA[`WDTIP_CTRL_FORCE_BIT];
            clr_stat = !IO_WDATA[`WDTIP_CTRL_STAT_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    // Countdown
    if (restart) begin
      st_next.remain = load_val;
    end else if (unit_pulse && running) begin
      if (st_reg.remain == 8'h01) begin
        expire = 1'b1;
        st_next.remain = 8'h00;
      end else begin
        st_next.remain = st_reg.remain - 8'h01;
      end
    end

    // Sticky status, set wins over clear
    if (clr_stat) begin
      st_next.status = 1'b0;
    end
    if (expire || force_to) begin
      st_next.status = 1'b1;
    end
    st_next.expire_q = expire || force_to;

    // Registered read data
    if (idx_rd) begin
      st_next.rdata = is_open ? st_reg.index : 8'h00;
    end else if (dat_rd) begin
      st_next.rdata = is_open ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign IO_RDATA = st_reg.rdata;
  assign WDT_TIMEOUT = st_reg.status;
  assign WDT_EXPIRE = st_reg.expire_q;
  assign CFG_OPEN = st_reg.cfg == WDTIP_OPEN;

  chk_unlock_pair: assert property (
    @(posedge CLK) disable iff (SRST)
    (st_reg.cfg == WDTIP_KEY1 && idx_wr && IO_WDATA == `WDTIP_KEY_ENTER)
      |=> CFG_OPEN)
    else $error("two enter keys did not unlock");

  chk_single_key: assert property (
    @(posedge CLK) disable iff (SRST)
    (st_reg.cfg == WDTIP_LOCKED && !idx_wr) |=> !CFG_OPEN)
    else $error("unlocked without key pair");

  chk_exit_lock: assert property (
    @(posedge CLK) disable iff (SRST)
    (CFG_OPEN && idx_wr && IO_WDATA == `WDTIP_KEY_EXIT) |=> !CFG_OPEN)
    else $error("exit key did not lock");

  chk_locked_write: assert property (
    @(posedge CLK) disable iff (SRST)
    (!CFG_OPEN && dat_wr) |=> ($stable(st_reg.count) && $stable(st_reg.act)
      && $stable(st_reg.group)))
    else $error("locked write changed a register");

  chk_count_reload: assert property (
    @(posedge CLK) disable iff (SRST)
    (CFG_OPEN && wdt_sel && dat_wr && st_reg.index == `WDTIP_IDX_COUNT)
      |=> (st_reg.remain == $past(IO_WDATA) && st_reg.count == $past(IO_WDATA)))
    else $error("count write did not restart countdown");

  chk_force_event: assert property (
    @(posedge CLK) disable iff (SRST)
    (CFG_OPEN && wdt_sel && dat_wr && st_reg.index == `WDTIP_IDX_CTRL
      && IO_WDATA[`WDTIP_CTRL_FORCE_BIT]) |=> (WDT_TIMEOUT && WDT_EXPIRE) ##1 !WDT_EXPIRE)
    else $error("forced timeout missing or not one cycle");

  chk_status_cause: assert property (
    @(posedge CLK) disable iff (SRST)
    $rose(WDT_TIMEOUT) |-> $past(expire || force_to))
    else $error("timeout without expiry or force");

  chk_status_sticky: assert property (
    @(posedge CLK) disable iff (SRST)
    (WDT_TIMEOUT && !clr_stat) |=> WDT_TIMEOUT)
    else $error("timeout status dropped without clear");

  chk_zero_stops: assert property (
    @(posedge CLK) disable iff (SRST)
    (st_reg.count == 8'h00) |-> (st_reg.remain == 8'h00 && !running))
    else $error("zero count left timer running");

  chk_disabled_hold: assert property (
    @(posedge CLK) disable iff (SRST)
    (!st_reg.act && !restart) |=> $stable(st_reg.remain))
    else $error("countdown moved while disabled");

  chk_reset_values: assert property (
    @(posedge CLK)
    SRST |=> (!CFG_OPEN && !st_reg.act && st_reg.count == 8'h00 && !st_reg.kb_en
      && !st_reg.unit_min && !WDT_TIMEOUT))
    else $error("reset values wrong");

endmodule : wdtip_top

// ### bench/wdtip_host.sv
`timescale 1ns/1ps
`include "wdtip_cfg.svh"
module wdtip_host (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // One strobed cycle; released address and data lines show the inverse of the last value
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic rd,
                     output logic [7:0] q);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= ~rd;
    io_rd <= rd;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    @(negedge clk);
    q = io_rdata;
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, d, 1'b0, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    bus(a, 8'h00, 1'b1, q);
  endtask : rd

  // Key pair unlocks
  task automatic unlock();
    wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
    wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
  endtask : unlock

  task automatic lock();
    wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_EXIT);
  endtask : lock

  // Index first, then data
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    wr(`WDTIP_ADDR_INDEX, idx);
    wr(`WDTIP_ADDR_DATA, v);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] v);
    wr(`WDTIP_ADDR_INDEX, idx);
    rd(`WDTIP_ADDR_DATA, v);
  endtask : cfg_rd

  task automatic sel_wdt();
    cfg_wr(`WDTIP_IDX_GROUP, `WDTIP_GROUP_WDT);
  endtask : sel_wdt
endmodule : wdtip_host

// ### bench/wdtip_top_tb_top.sv
`timescale 1ns/1ps
`include "wdtip_cfg.svh"
module wdtip_top_tb_top;
  localparam int MS = 4;
  logic CLK;
  logic SRST;
  logic [15:0] IO_ADDR;
  logic IO_WR;
  logic IO_RD;
  logic [7:0] IO_WDATA;
  logic [7:0] IO_RDATA;
  logic KB_ACT;
  logic MS_ACT;
  logic WDT_TIMEOUT;
  logic WDT_EXPIRE;
  logic CFG_OPEN;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  wdtip_top #(.MS_CYCLES(MS)) i_dut (.CLK(CLK), .SRST(SRST), .IO_ADDR(IO_ADDR),
    .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .KB_ACT(KB_ACT), .MS_ACT(MS_ACT), .WDT_TIMEOUT(WDT_TIMEOUT),
    .WDT_EXPIRE(WDT_EXPIRE), .CFG_OPEN(CFG_OPEN));
  wdtip_host i_host (.clk(CLK), .io_addr(IO_ADDR), .io_wr(IO_WR), .io_rd(IO_RD),
    .io_wdata(IO_WDATA), .io_rdata(IO_RDATA));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Cycles until the expiry pulse, capped
  task automatic wait_exp(input int maxc, output int n);
    n = 0;
    while (WDT_EXPIRE !== 1'b1 && n < maxc) begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask : wait_exp

  task automatic t_keys();
    logic [7:0] v;
    chk({7'h0, CFG_OPEN}, 8'h00, "open after reset");
    chk({7'h0, WDT_TIMEOUT}, 8'h00, "timeout after reset");
    i_host.wr(16'h002d, `WDTIP_KEY_ENTER);
    i_host.wr(16'h002d, `WDTIP_KEY_ENTER);
    chk({7'h0, CFG_OPEN}, 8'h00, "unmapped keys");
    i_host.wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
    i_host.wr(`WDTIP_ADDR_INDEX, 8'h55);
    i_host.wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
    chk({7'h0, CFG_OPEN}, 8'h00, "broken key pair");
    i_host.wr(`WDTIP_ADDR_INDEX, 8'h55);
    i_host.wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
    chk({7'h0, CFG_OPEN}, 8'h00, "single key");
    i_host.wr(`WDTIP_ADDR_INDEX, `WDTIP_KEY_ENTER);
    chk({7'h0, CFG_OPEN}, 8'h01, "unlock");
    i_host.sel_wdt();
    i_host.cfg_rd(`WDTIP_IDX_ACT, v);
    chk(v, 8'h00, "activate reset");
    i_host.cfg_rd(`WDTIP_IDX_UNIT, v);
    chk(v, 8'h00, "unit reset");
    i_host.cfg_rd(`WDTIP_IDX_COUNT, v);
    chk(v, 8'h00, "count reset");
    i_host.cfg_rd(`WDTIP_IDX_CTRL, v);
    chk(v, 8'h00, "ctrl reset");
    i_host.rd(`WDTIP_ADDR_INDEX, v);
    chk(v, `WDTIP_IDX_CTRL, "index readback");
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'hc0);
    i_host.cfg_rd(`WDTIP_IDX_CTRL, v);
    chk(v, 8'hc0, "activity enables");
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'h00);
    i_host.lock();
    chk({7'h0, CFG_OPEN}, 8'h00, "lock");
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h05);
    i_host.rd(`WDTIP_ADDR_DATA, v);
    chk(v, 8'h00, "locked read");
    i_host.unlock();
    i_host.cfg_rd(`WDTIP_IDX_COUNT, v);
    chk(v, 8'h00, "locked write ignored");
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h3c);
    i_host.rd(`WDTIP_ADDR_DATA, v);
    chk(v, 8'h3c, "data to last index");
    i_host.cfg_rd(`WDTIP_IDX_UNIT, v);
    chk(v, 8'h00, "data goes to last index");
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h00);
  endtask : t_keys

  task automatic t_force();
    logic [7:0] v;
    int n;
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'h20);
    wait_exp(3, n);
    chk({7'h0, n < 3}, 8'h01, "forced pulse");
    chk({7'h0, WDT_TIMEOUT}, 8'h01, "forced timeout");
    i_host.cfg_rd(`WDTIP_IDX_CTRL, v);
    chk(v, 8'h10, "status set, force cleared");
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'h10);
    chk({7'h0, WDT_TIMEOUT}, 8'h01, "write one keeps status");
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'h00);
    chk({7'h0, WDT_TIMEOUT}, 8'h00, "write zero clears");
  endtask : t_force

  // Start a countdown and time the expiry
  task automatic t_count(input logic [7:0] act, input logic [7:0] unit,
                         input logic [7:0] cnt, input int lo, input int hi);
    int n;
    int lim;
    lim = (hi > 0) ? hi + 1 : lo;
    i_host.cfg_wr(`WDTIP_IDX_CTRL, 8'h00);
    i_host.cfg_wr(`WDTIP_IDX_ACT, act);
    i_host.cfg_wr(`WDTIP_IDX_UNIT, unit);
    i_host.cfg_wr(`WDTIP_IDX_COUNT, cnt);
    wait_exp(lim, n);
    chk({7'h0, n < lim}, {7'h0, hi > 0}, "expiry seen");
    chk({7'h0, n >= lo || hi == 0}, 8'h01, "expiry not early");
    chk({7'h0, WDT_TIMEOUT}, {7'h0, hi > 0}, "timeout level");
  endtask : t_count

  task automatic t_timer();
    int n;
    t_count(8'h01, 8'h10, 8'h03, 3 * MS - 3, 3 * MS + 3);
    t_count(8'h01, 8'h18, 8'h01, 60 * MS - 3, 60 * MS + 3);
    t_count(8'h01, 8'h00, 8'h01, 1000 * MS - 3, 1000 * MS + 3);
    t_count(8'h01, 8'h10, 8'hff, 255 * MS - 3, 255 * MS + 3);
    t_count(8'h01, 8'h10, 8'h00, 100, 0);
    t_count(8'h00, 8'h10, 8'h05, 100, 0);
    i_host.cfg_wr(`WDTIP_IDX_ACT, 8'h01);
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h06);
    repeat (5 * MS) @(posedge CLK);
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h06);
    wait_exp(6 * MS + 3, n);
    chk({7'h0, n >= 6 * MS - 3 && n <= 6 * MS + 3}, 8'h01, "restart");
  endtask : t_timer

  task automatic t_activity(input logic kb, input logic [7:0] ctrl, input logic hold);
    int n;
    i_host.cfg_wr(`WDTIP_IDX_CTRL, ctrl);
    i_host.cfg_wr(`WDTIP_IDX_COUNT, 8'h04);
    repeat (6) begin
      @(posedge CLK);
      KB_ACT <= kb;
      MS_ACT <= ~kb;
      repeat (3) @(posedge CLK);
      KB_ACT <= 1'b0;
      MS_ACT <= 1'b0;
      repeat (3) @(posedge CLK);
    end
    #1;
    chk({7'h0, WDT_TIMEOUT}, {7'h0, ~hold}, "activity restart");
    if (hold) begin
      wait_exp(4 * MS + 8, n);
      chk({7'h0, n < 4 * MS + 8}, 8'h01, "expiry after activity");
    end
  endtask : t_activity

  initial begin
    SRST = 1'b1;
    KB_ACT = 1'b0;
    MS_ACT = 1'b0;
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    #1;
    t_keys();
    t_force();
    t_timer();
    t_activity(1'b1, 8'h40, 1'b1);
    t_activity(1'b0, 8'h80, 1'b1);
    t_activity(1'b1, 8'h80, 1'b0);
    t_activity(1'b0, 8'h40, 1'b0);
    test_done();
  end
endmodule : wdtip_top_tb_top
